/* File: design/gpjk_defs.vh */
// Contract
// - port k has three independent bidirectional pins
// - per-bit output and input enables for k
// - k pins carry timer, clock, alarm functions
// - reset leaves k pins gpio, all disabled
// - k pin 0 is open-drain only
// - k data in bits 2:0 at 0x0000
// - k output enable bits 2:0 at 0x0004
// - k function select a at 0x0008
// - k function select b at 0x000C
// - k pullup 0x002C, input enable 0x0038
// - j function bits pick which pins reach irqs in stop
// - j bits 5,4 route timer 7,6 outputs
// - j pullup bits 7:0, reset zero
// - j input enable bits 7:0, reset zero
// - outside stop, input enable passes irq, except pins 5,4 which never reach it
`ifndef GPJK_DEFS_VH
`define GPJK_DEFS_VH
`define GPJK_OFF_K_DATA   12'h000
`define GPJK_OFF_K_OE     12'h004
`define GPJK_OFF_K_FSA    12'h008
`define GPJK_OFF_K_FSB    12'h00C
`define GPJK_OFF_K_PU     12'h02C
`define GPJK_OFF_K_IE     12'h038
`define GPJK_OFF_J_FSA    12'h048
`define GPJK_OFF_J_PU     12'h06C
`define GPJK_OFF_J_IE     12'h078
`define GPJK_K_MASK       3'h7
`define GPJK_K_FSB_MASK   3'h2
`define GPJK_K_PU_MASK    3'h6
`define GPJK_J_TMR_MASK   8'h30
`define GPJK_RST_K        3'h0
`define GPJK_RST_J        8'h00
`endif

/* File: design/gpjk_port.v */
`timescale 1ns/1ns
`include "gpjk_defs.vh"
module gpjk_port (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [2:0]  k_pin_in,
    output reg  [2:0]  k_pin_out,
    output reg  [2:0]  k_pin_oe_n,
    output reg  [2:0]  k_pullup_on,
    input  wire        timer9_output,
    input  wire        clock_out_src,
    input  wire        alarm_out_src,
    input  wire [7:0]  j_pin_in,
    input  wire        timer6_output,
    input  wire        timer7_output,
    input  wire        stop_mode,
    output reg  [7:0]  j_pullup_on,
    output reg  [7:0]  j_input_buf_on,
    output reg  [1:0]  j_timer_out,
    output reg  [1:0]  j_timer_sel,
    output reg  [7:0]  external_irq_in
);
    reg  [2:0]  port_k_pin_data_ff;
    reg  [2:0]  port_k_output_enable_ff;
    reg  [2:0]  port_k_function_select_a_ff;
    reg  [2:0]  port_k_function_select_b_ff;
    reg  [2:0]  port_k_pullup_enable_ff;
    reg  [2:0]  port_k_input_enable_ff;
    reg  [7:0]  port_j_function_select_a_ff;
    reg  [7:0]  port_j_pullup_enable_ff;
    reg  [7:0]  port_j_input_enable_ff;
    reg  [2:0]  k_sync1_ff;
    reg  [2:0]  k_sync2_ff;
    reg  [7:0]  j_sync1_ff;
    reg  [7:0]  j_sync2_ff;
    reg  [2:0]  nxt_k_out;
    reg  [2:0]  nxt_k_oe_n;
    reg  [31:0] nxt_rdata;
    reg         nxt_err;
    wire        acc;
    wire        wr;

    // true when address names a mapped register
    function hit;
        input [11:0] a;
        begin
            case (a)
                `GPJK_OFF_K_DATA, `GPJK_OFF_K_OE, `GPJK_OFF_K_FSA,
                `GPJK_OFF_K_FSB, `GPJK_OFF_K_PU, `GPJK_OFF_K_IE,
                `GPJK_OFF_J_FSA, `GPJK_OFF_J_PU, `GPJK_OFF_J_IE: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    endfunction

    // pready is registered, so access phase lasts two cycles
    assign acc = psel & penable & ~pready;
    assign wr  = acc & pwrite & hit(paddr);

    always @(posedge core_clk) begin
        k_sync1_ff <= k_pin_in;
        k_sync2_ff <= k_sync1_ff;
        j_sync1_ff <= j_pin_in;
        j_sync2_ff <= j_sync1_ff;
    end

    always @(posedge core_clk) begin
        if (rst) begin
            port_k_pin_data_ff          <= `GPJK_RST_K;
            port_k_output_enable_ff     <= `GPJK_RST_K;
            port_k_function_select_a_ff <= `GPJK_RST_K;
            port_k_function_select_b_ff <= `GPJK_RST_K;
            port_k_pullup_enable_ff     <= `GPJK_RST_K;
            port_k_input_enable_ff      <= `GPJK_RST_K;
            port_j_function_select_a_ff <= `GPJK_RST_J;
            port_j_pullup_enable_ff     <= `GPJK_RST_J;
            port_j_input_enable_ff      <= `GPJK_RST_J;
        end else if (wr) begin
            case (paddr)
                `GPJK_OFF_K_DATA: port_k_pin_data_ff <= pwdata[2:0];
                `GPJK_OFF_K_OE:   port_k_output_enable_ff <= pwdata[2:0];
                `GPJK_OFF_K_FSA:  port_k_function_select_a_ff <= pwdata[2:0];
                `GPJK_OFF_K_FSB:
                    port_k_function_select_b_ff <= pwdata[2:0] & `GPJK_K_FSB_MASK;
                `GPJK_OFF_K_PU:
                    port_k_pullup_enable_ff <= pwdata[2:0] & `GPJK_K_PU_MASK;
                `GPJK_OFF_K_IE:   port_k_input_enable_ff <= pwdata[2:0];
                `GPJK_OFF_J_FSA:  port_j_function_select_a_ff <= pwdata[7:0];
                `GPJK_OFF_J_PU:   port_j_pullup_enable_ff <= pwdata[7:0];
                `GPJK_OFF_J_IE:   port_j_input_enable_ff <= pwdata[7:0];
                default: port_k_pin_data_ff <= port_k_pin_data_ff;
            endcase
        end
    end

    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = acc & ~hit(paddr);
        case (paddr)
            // sampled pin where input enabled, stored value otherwise
            `GPJK_OFF_K_DATA: nxt_rdata[2:0] = (k_sync2_ff & port_k_input_enable_ff)
                | (port_k_pin_data_ff & ~port_k_input_enable_ff);
            `GPJK_OFF_K_OE:  nxt_rdata[2:0] = port_k_output_enable_ff;
            `GPJK_OFF_K_FSA: nxt_rdata[2:0] = port_k_function_select_a_ff;
            `GPJK_OFF_K_FSB: nxt_rdata[2:0] = port_k_function_select_b_ff;
            `GPJK_OFF_K_PU:  nxt_rdata[2:0] = port_k_pullup_enable_ff;
            `GPJK_OFF_K_IE:  nxt_rdata[2:0] = port_k_input_enable_ff;
            `GPJK_OFF_J_FSA: nxt_rdata[7:0] = port_j_function_select_a_ff;
            `GPJK_OFF_J_PU:  nxt_rdata[7:0] = port_j_pullup_enable_ff;
            `GPJK_OFF_J_IE:  nxt_rdata[7:0] = port_j_input_enable_ff;
            default:         nxt_rdata = 32'h0000_0000;
        endcase
    end

    // k pin drive: alternate sources override data when selected
    always @* begin
        nxt_k_out = port_k_pin_data_ff;
        if (port_k_function_select_a_ff[2])
            nxt_k_out[2] = timer9_output;
        if (port_k_function_select_a_ff[1])
            nxt_k_out[1] = clock_out_src;
        else if (port_k_function_select_b_ff[1])
            nxt_k_out[1] = alarm_out_src;
        nxt_k_oe_n = ~port_k_output_enable_ff;
        // open drain: only ever sink low, release otherwise
        nxt_k_oe_n[0] = ~(port_k_output_enable_ff[0] & ~nxt_k_out[0]);
        nxt_k_out[0]  = 1'b0;
    end

    always @(posedge core_clk) begin
        if (rst) begin
            prdata          <= 32'h0000_0000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            k_pin_out       <= `GPJK_RST_K;
            k_pin_oe_n      <= `GPJK_K_MASK;
            k_pullup_on     <= `GPJK_RST_K;
            j_pullup_on     <= `GPJK_RST_J;
            j_input_buf_on  <= `GPJK_RST_J;
            j_timer_out     <= 2'h0;
            j_timer_sel     <= 2'h0;
            external_irq_in <= `GPJK_RST_J;
        end else begin
            pready          <= acc;
            pslverr         <= nxt_err;
            prdata          <= (acc & ~pwrite) ? nxt_rdata : 32'h0000_0000;
            k_pin_out       <= nxt_k_out;
            k_pin_oe_n      <= nxt_k_oe_n;
            k_pullup_on     <= port_k_pullup_enable_ff;
            j_pullup_on     <= port_j_pullup_enable_ff;
            j_input_buf_on  <= port_j_input_enable_ff;
            j_timer_sel     <= port_j_function_select_a_ff[5:4];
            j_timer_out     <= {timer7_output, timer6_output} &
                               port_j_function_select_a_ff[5:4];
            // in stop only function-selected pins wake; ie gates in and out of stop, and pins 5,4 never pass
            external_irq_in <= j_sync2_ff & port_j_input_enable_ff & ~`GPJK_J_TMR_MASK &
                (stop_mode ? port_j_function_select_a_ff : 8'hFF);
        end
    end
endmodule

/* File: verification/gpio_port_j_k_control_bench.sv */
`timescale 1ns/1ns
`include "gpjk_defs.vh"
module gpio_port_j_k_control_bench;
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err, timer9_output;
    logic        clock_out_src, alarm_out_src, timer6_output, timer7_output, stop_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  k_pin_in, k_pin_out, k_pin_oe_n, k_pullup_on, ext_drv, ext_val;
    logic [7:0]  j_pin_in, j_pullup_on, j_input_buf_on, external_irq_in;
    logic [1:0]  j_timer_out, j_timer_sel;
    int          mismatches, n_compared, cycles;
    logic [11:0] offs [9] = '{`GPJK_OFF_K_DATA, `GPJK_OFF_K_OE, `GPJK_OFF_K_FSA, `GPJK_OFF_K_FSB,
        `GPJK_OFF_K_PU, `GPJK_OFF_K_IE, `GPJK_OFF_J_FSA, `GPJK_OFF_J_PU, `GPJK_OFF_J_IE};
    logic [31:0] masks [9] = '{32'h7, 32'h7, 32'h7, 32'h2, 32'h6, 32'h7, 32'hFF, 32'hFF, 32'hFF};
    gpjk_port  uut (.*);
    gpjk_board board (.*);
    initial begin
        core_clk = 0;
        forever #2 core_clk = ~core_clk;
    end
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one idle edge after each transfer keeps strobes from double assignment
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge core_clk) penable <= 1;
        do @(posedge core_clk); while (pready !== 1'h1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge core_clk);
    endtask
    task t_reset;
        for (int i = 0; i < 9; i++) begin
            apb(0, offs[i], 0);
            chk(rd, 0);
        end
        chk(k_pin_oe_n, 3'h7);
    endtask
    task t_regs;
        for (int i = 0; i < 9; i++) begin
            apb(1, offs[i], 32'hFFFFFFFF);
            apb(0, offs[i], 0);
            chk(rd, masks[i]);
        end
        apb(0, 12'h010, 0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
    endtask
    task t_pins;
        repeat (2) @(posedge core_clk);
        chk({k_pin_out, k_pin_oe_n, k_pullup_on}, 9'h10E);
        chk({j_pullup_on, j_input_buf_on, j_timer_out}, 18'h3FFFE);
        chk(j_timer_sel, 2'h3);
        apb(1, `GPJK_OFF_K_DATA, 0);
        @(posedge core_clk);
        chk(k_pin_oe_n, 3'h0);
    endtask
    task t_irq;
        // timer pins 5,4 driven high too, so their mask is exercised
        j_pin_in <= 8'hFF;
        repeat (6) @(posedge core_clk);
        chk(external_irq_in, 8'hCF);
        stop_mode <= 1;
        apb(1, `GPJK_OFF_J_FSA, 32'h81);
        repeat (6) @(posedge core_clk);
        chk(external_irq_in, 8'h81);
        stop_mode <= 0;
        repeat (6) @(posedge core_clk);
        chk(external_irq_in, 8'hCF);
    endtask
    task t_data_in;
        apb(1, `GPJK_OFF_K_OE, 0);
        ext_drv <= 3'h7; ext_val <= 3'h5;
        repeat (4) @(posedge core_clk);
        apb(0, `GPJK_OFF_K_DATA, 0);
        chk(rd, 32'h5);
    endtask
    initial begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; stop_mode = 0;
        timer9_output = 1; clock_out_src = 0; alarm_out_src = 0; timer6_output = 0;
        timer7_output = 1; j_pin_in = 0; ext_drv = 0; ext_val = 0;
        repeat (16) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        t_reset; t_regs; t_pins; t_irq; t_data_in;
        end_of_test;
    end
endmodule

/* File: verification/gpjk_board.sv */
`timescale 1ns/1ns
module gpjk_board (
    input  logic       core_clk,
    input  logic [2:0] k_pin_out,
    input  logic [2:0] k_pin_oe_n,
    input  logic [2:0] k_pullup_on,
    input  logic [2:0] ext_drv,
    input  logic [2:0] ext_val,
    output logic [2:0] k_pin_in
);
    // undriven line toggles, so a float never reads as a steady level
    logic [2:0] junk_ff = 3'h5;
    always @(posedge core_clk) junk_ff <= ~junk_ff;
    always_comb for (int i = 0; i < 3; i++) k_pin_in[i] = !k_pin_oe_n[i] ? k_pin_out[i] :
        ext_drv[i] ? ext_val[i] : k_pullup_on[i] ? 1'h1 : junk_ff[i];
endmodule

/* File: verification/gpjk_props.sv */
`timescale 1ns/1ns
module gpjk_props (
    input logic        core_clk,
    input logic        rst,
    input logic        psel,
    input logic        penable,
    input logic        pready,
    input logic        pslverr,
    input logic [31:0] prdata,
    input logic [2:0]  k_pin_out,
    input logic [7:0]  j_input_buf_on,
    input logic [1:0]  j_timer_sel,
    input logic [1:0]  j_timer_out,
    input logic [7:0]  external_irq_in
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_taken;
        psel && penable && !pready;
    endsequence
    chk_answer_next: assert property (s_taken |=> pready) else $error("no answer");
    chk_single_pulse: assert property (pready |=> !pready) else $error("long ready");
    chk_err_ready: assert property (pslverr |-> pready) else $error("lone error");
    chk_rsvd_zero: assert property (prdata[31:8] == 24'h0) else $error("upper bits");
    chk_open_drain: assert property (k_pin_out[0] == 1'h0) else $error("k0 high");
    chk_timer_no_irq: assert property (external_irq_in[5:4] == 2'h0) else $error("irq 5:4");
    chk_irq_gated: assert property ((j_input_buf_on == 8'h00) [*6] |-> external_irq_in == 8'h00)
        else $error("irq no ie");
    chk_timer_gated: assert property ((j_timer_sel == 2'h0) [*2] |-> j_timer_out == 2'h0)
        else $error("timer no sel");
endmodule
bind gpjk_port gpjk_props chk (.*);
